// *** core/rhs_params.svh ***
`ifndef RHS_PARAMS_SVH
`define RHS_PARAMS_SVH

// ============================================================
// register placement
`define RHS_ROOT_HUB_STATUS_OFS  12'h050
`define RHS_ADDR_W               12

// ============================================================
// field positions
`define RHS_BIT_CLR_WAKE         31
`define RHS_BIT_OC_CHANGE        17
`define RHS_BIT_SET_GLOBAL_PWR   16
`define RHS_BIT_WAKE_EN          15
`define RHS_BIT_OC_FLAG          1
`define RHS_BIT_CLR_GLOBAL_PWR   0

// ============================================================
// reset values
`define RHS_RESET_VALUE          32'h0000_0000
`define RHS_PORT_PWR_RESET       16'h0000

`endif

// *** core/rhs_pkg.sv ***
package rhs_pkg;

  // all state of the root hub status block
  typedef struct packed {
    logic [2:0]  oc_sync;
    logic        oc_flag;
    logic        oc_change;
    logic        wake_en;
    logic [15:0] port_pwr;
    logic        resume;
    logic [31:0] rdata;
  } rhs_state_type;

  // register access request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [31:0] wdata;
  } rhs_req_type;

endpackage : rhs_pkg

// *** core/rhs_root_hub_status.sv ***
// Operation
// - register sits at offset 50h
// - low half status, high half change
// - write one bit 31 clears wake enable
// - overcurrent indicator change sets bit 17
// - write one clears bit 17, zero ignored
// - bit 16 always reads zero
// - global mode: bit 16 powers all ports
// - per-port mode: bit 16 powers unmasked ports
// - wake enable: connect change resumes suspended host
// - write one bit 15 sets wake enable
// - bit 1 shows global overcurrent, read-only
// - per-port overcurrent: bit 1 stays zero
// - bit 0 always reads zero
// - global mode: bit 0 unpowers all ports
// - per-port mode: bit 0 unpowers unmasked ports
// - switching mode selects global or per-port
// - per-port mode: mask bit per port excludes global commands
`timescale 1ns/10ps
`default_nettype none
`include "rhs_params.svh"

module rhs_root_hub_status
  import rhs_pkg::*;
#(
  parameter int N_PORTS   = 2,
  parameter bit GLOBAL_OC = 1'b1
) (
  input  wire logic                 CLK,
  input  wire logic                 RST_N,
  input  wire logic                 REG_WR,
  input  wire logic                 REG_RD,
  input  wire logic [11:0]          REG_ADDR,
  input  wire logic [31:0]          REG_WDATA,
  output logic      [31:0]          REG_RDATA,
  input  wire logic                 POWER_SWITCH_MODE,
  input  wire logic [N_PORTS:1]     PORT_POWER_MASK,
  input  wire logic [N_PORTS:1]     PORT_POWER_SET,
  input  wire logic [N_PORTS:1]     PORT_POWER_CLR,
  input  wire logic                 OVERCURRENT_IN,
  input  wire logic [N_PORTS:1]     PORT_CONNECT_CHANGE,
  input  wire logic                 HOST_SUSPENDED_STATE,
  output logic      [N_PORTS:1]     PORT_POWER_ON,
  output logic                      RESUME_DETECTED
);

  // ============================================================
  // state
  rhs_state_type st_r;
  rhs_state_type st_nxt;
  rhs_req_type   req;

  logic          hit_wr;
  logic          hit_rd;
  logic [15:0]   glob_sel;
  logic [15:0]   mask_full;
  logic [15:0]   pset_full;
  logic [15:0]   pclr_full;
  logic          oc_new;

  // ============================================================
  // helpers

  // offset decode, shared by the read and the write path
  function automatic logic addr_hit(input logic [11:0] addr);
    return addr == `RHS_ROOT_HUB_STATUS_OFS;
  endfunction

  // port vector placed in the 16-bit field; bit 0 has no port
  function automatic logic [15:0] widen_ports(
    input logic [N_PORTS:1] v
  );
    logic [15:0] w;
    w = 16'h0000;
    for (int i = 1; i <= N_PORTS; i++) begin
      w[i] = v[i];
    end
    return w;
  endfunction

  // ports that obey the global commands in the present mode
  function automatic logic [15:0] global_ports(
    input logic        per_port_mode,
    input logic [15:0] mask
  );
    logic [15:0] sel;
    sel = widen_ports({N_PORTS{1'b1}});
    if (per_port_mode) begin
      sel = sel & ~mask;
    end
    return sel;
  endfunction

  // filtered overcurrent level; a lone disagreeing sample is a
  // glitch on the pin and leaves the flag where it was
  function automatic logic oc_filter(
    input logic [2:0] sync,
    input logic       flag
  );
    logic lvl;
    lvl = flag;
    if (sync[1] == sync[2]) begin
      lvl = sync[2];
    end
    if (!GLOBAL_OC) begin
      lvl = 1'b0;
    end
    return lvl;
  endfunction

  // power of the ports after one clock; per-port commands touch only
  // masked ports, the global ones the rest in per-port mode and all in global mode, and a global set is
  // applied after the clear so a write of both leaves power on
  function automatic logic [15:0] next_power(
    input logic [15:0] pwr,
    input logic        per_port_mode,
    input logic [15:0] mask,
    input logic [15:0] pset,
    input logic [15:0] pclr,
    input logic [15:0] sel,
    input logic        glob_clr,
    input logic        glob_set
  );
    logic [15:0] p;
    p = pwr;
    if (per_port_mode) begin
      p = (p | (pset & mask)) & ~(pclr & mask);
    end
    if (glob_clr) begin
      p = p & ~sel;
    end
    if (glob_set) begin
      p = p | sel;
    end
    return p;
  endfunction

  // ============================================================
  // request decode
  assign req.wr    = REG_WR;
  assign req.rd    = REG_RD;
  assign req.addr  = REG_ADDR;
  assign req.wdata = REG_WDATA;

  assign hit_wr = req.wr && addr_hit(req.addr);
  assign hit_rd = req.rd && addr_hit(req.addr);

  assign mask_full = widen_ports(PORT_POWER_MASK);
  assign pset_full = widen_ports(PORT_POWER_SET);
  assign pclr_full = widen_ports(PORT_POWER_CLR);
  assign glob_sel  = global_ports(POWER_SWITCH_MODE, mask_full);
  assign oc_new    = oc_filter(st_r.oc_sync, st_r.oc_flag);

  // ============================================================
  // next state
  always_comb begin
    st_nxt = st_r;

    // the pin passes two flops before the filter looks at it, then compares the second flop with the third
    st_nxt.oc_sync = {st_r.oc_sync[1:0], OVERCURRENT_IN};
    st_nxt.oc_flag = oc_new;

    // software clear first, so a same-cycle hardware change wins
    if (hit_wr && req.wdata[`RHS_BIT_OC_CHANGE]) begin
      st_nxt.oc_change = 1'b0;
    end
    if (oc_new != st_r.oc_flag) begin
      st_nxt.oc_change = 1'b1;
    end

    if (hit_wr && req.wdata[`RHS_BIT_CLR_WAKE]) begin
      st_nxt.wake_en = 1'b0;
    end
    // set and clear together: set taken, the enable stays on
    if (hit_wr && req.wdata[`RHS_BIT_WAKE_EN]) begin
      st_nxt.wake_en = 1'b1;
    end

    // per-port commands only reach masked ports in per-port mode
    st_nxt.port_pwr = next_power(st_r.port_pwr, POWER_SWITCH_MODE,
      mask_full, pset_full, pclr_full, glob_sel,
      hit_wr && req.wdata[`RHS_BIT_CLR_GLOBAL_PWR],
      hit_wr && req.wdata[`RHS_BIT_SET_GLOBAL_PWR]);

    st_nxt.resume = st_r.wake_en && HOST_SUSPENDED_STATE
                    && (|PORT_CONNECT_CHANGE);

    // local power bits and the strobes read as zero
    st_nxt.rdata = 32'h0000_0000;
    if (hit_rd) begin
      st_nxt.rdata[`RHS_BIT_OC_CHANGE] = st_r.oc_change;
      st_nxt.rdata[`RHS_BIT_WAKE_EN]   = st_r.wake_en;
      st_nxt.rdata[`RHS_BIT_OC_FLAG]   = st_r.oc_flag;
    end
  end

  // ============================================================
  // registers
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      // chain starts at the idle pin level, so no false change follows
      st_r.oc_sync   <= 3'h0;
      st_r.oc_flag   <= 1'b0;
      st_r.oc_change <= 1'b0;
      st_r.wake_en   <= 1'b0;
      st_r.port_pwr  <= `RHS_PORT_PWR_RESET;
      st_r.resume    <= 1'b0;
      st_r.rdata     <= `RHS_RESET_VALUE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ============================================================
  // outputs
  assign REG_RDATA       = st_r.rdata;
  assign PORT_POWER_ON   = st_r.port_pwr[N_PORTS:1];
  assign RESUME_DETECTED = st_r.resume;

endmodule // rhs_root_hub_status

`default_nettype wire

// *** tb/rhs_props.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "rhs_params.svh"
module rhs_props #(parameter int N_PORTS = 2) (
  input wire logic               CLK,
  input wire logic               RST_N,
  input wire logic               REG_WR,
  input wire logic               REG_RD,
  input wire logic [11:0]        REG_ADDR,
  input wire logic [31:0]        REG_WDATA,
  input wire logic [31:0]        REG_RDATA,
  input wire logic               POWER_SWITCH_MODE,
  input wire logic [N_PORTS:1]   PORT_POWER_MASK,
  input wire logic [N_PORTS:1]   PORT_POWER_SET,
  input wire logic [N_PORTS:1]   PORT_POWER_CLR,
  input wire logic [N_PORTS:1]   PORT_CONNECT_CHANGE,
  input wire logic               HOST_SUSPENDED_STATE,
  input wire logic [N_PORTS:1]   PORT_POWER_ON,
  input wire logic               RESUME_DETECTED
);
  wire wr = REG_WR && REG_ADDR == `RHS_ROOT_HUB_STATUS_OFS;
  wire rd = REG_RD && REG_ADDR == `RHS_ROOT_HUB_STATUS_OFS;
  wire pp = POWER_SWITCH_MODE && !(|PORT_POWER_SET) && !(|PORT_POWER_CLR);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  property p_ref; REG_RD && !rd |=> REG_RDATA == '0; endproperty
  a_ref: assert property (p_ref) else $error("bad read");
  property p_idl; !REG_RD |=> REG_RDATA == '0; endproperty
  a_idl: assert property (p_idl) else $error("idle data");
  property p_lp; !REG_RDATA[16] && !REG_RDATA[0]; endproperty
  a_lp: assert property (p_lp) else $error("local power");
  property p_ws; wr && REG_WDATA[15] ##1 rd |=> REG_RDATA[15]; endproperty
  a_ws: assert property (p_ws) else $error("wake set");
  property p_wc; wr && REG_WDATA[31] && !REG_WDATA[15] ##1 rd
    |=> !REG_RDATA[15]; endproperty
  a_wc: assert property (p_wc) else $error("wake clr");
  property p_gon; wr && REG_WDATA[16] && !POWER_SWITCH_MODE
    |=> &PORT_POWER_ON; endproperty
  a_gon: assert property (p_gon) else $error("power on");
  property p_gof; wr && REG_WDATA[0] && !REG_WDATA[16] && !POWER_SWITCH_MODE
    |=> PORT_POWER_ON == '0; endproperty
  a_gof: assert property (p_gof) else $error("power off");
  property p_pon; wr && REG_WDATA[16] && pp |=> PORT_POWER_ON ==
    ($past(PORT_POWER_ON) | ~$past(PORT_POWER_MASK)); endproperty
  a_pon: assert property (p_pon) else $error("port on");
  property p_pof; wr && REG_WDATA[0] && !REG_WDATA[16] && pp |=>
    PORT_POWER_ON == ($past(PORT_POWER_ON) & $past(PORT_POWER_MASK));
  endproperty
  a_pof: assert property (p_pof) else $error("port off");
  property p_res; RESUME_DETECTED
    |-> $past(HOST_SUSPENDED_STATE && |PORT_CONNECT_CHANGE); endproperty
  a_res: assert property (p_res) else $error("resume");
endmodule // rhs_props
bind rhs_root_hub_status rhs_props #(.N_PORTS(N_PORTS)) u_props (.CLK,
  .RST_N, .REG_WR, .REG_RD, .REG_ADDR, .REG_WDATA, .REG_RDATA,
  .POWER_SWITCH_MODE, .PORT_POWER_MASK, .PORT_POWER_SET, .PORT_POWER_CLR,
  .PORT_CONNECT_CHANGE, .HOST_SUSPENDED_STATE, .PORT_POWER_ON,
  .RESUME_DETECTED);
`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "rhs_params.svh"
module tb;
  logic CLK = 0, RST_N = 0, REG_WR = 0, REG_RD = 0, OVERCURRENT_IN = 0;
  logic POWER_SWITCH_MODE = 0, HOST_SUSPENDED_STATE = 0, RESUME_DETECTED;
  logic [11:0] REG_ADDR = '0;
  logic [31:0] REG_WDATA = '0, REG_RDATA, s = 32'h0000_c758, x;
  logic [2:1] PORT_POWER_MASK = '0, PORT_POWER_SET = '0, PORT_POWER_CLR = '0;
  logic [2:1] PORT_CONNECT_CHANGE = '0, PORT_POWER_ON;
  logic wake = 0, chg = 0, oc = 0, rd_d = 0, ev = 0;
  logic [2:1] pwr = '0, sel;
  logic [31:0] q[$];
  logic [2:1] qp[$];
  logic qr[$];
  int n_fail = 0, total_checks = 0, cyc = 0;
  rhs_root_hub_status dut (.CLK, .RST_N, .REG_WR, .REG_RD, .REG_ADDR,
    .REG_WDATA, .REG_RDATA, .POWER_SWITCH_MODE, .PORT_POWER_MASK,
    .PORT_POWER_SET, .PORT_POWER_CLR, .OVERCURRENT_IN, .PORT_CONNECT_CHANGE,
    .HOST_SUSPENDED_STATE, .PORT_POWER_ON, .RESUME_DETECTED);
  function logic [31:0] xs();
    s = s ^ (s << 13); s = s ^ (s >> 17); s = s ^ (s << 5);
    return s;
  endfunction
  task report_and_stop();
    $display("checks %0d fails %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk_rd(input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch REG_RDATA exp %h got %h", e, g);
    end
  endtask
  task chk_pwr(input logic [2:1] e, input logic [2:1] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch PORT_POWER_ON exp %h got %h", e, g);
    end
  endtask
  task chk_res(input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch RESUME_DETECTED exp %h got %h", e, g);
    end
  endtask
  // optional write, then a read of the same address at the next edge
  task xfer(input logic [11:0] a, input logic [31:0] d, input logic w);
    if (w && a == `RHS_ROOT_HUB_STATUS_OFS) begin
      if (d[15]) wake = 1; else if (d[31]) wake = 0;
      if (d[17]) chg = ev;
    end
    if (w) begin
      @(posedge CLK); REG_WR <= 1; REG_ADDR <= a; REG_WDATA <= d;
    end
    @(posedge CLK); REG_WR <= 0; REG_RD <= 1; REG_ADDR <= a;
    // inputs driven before the call have settled by now
    sel = POWER_SWITCH_MODE ? ~PORT_POWER_MASK : 2'b11;
    if (POWER_SWITCH_MODE) begin
      pwr = (pwr | (PORT_POWER_SET & PORT_POWER_MASK))
            & ~(PORT_POWER_CLR & PORT_POWER_MASK);
    end
    if (w && a == `RHS_ROOT_HUB_STATUS_OFS && d[0]) pwr = pwr & ~sel;
    if (w && a == `RHS_ROOT_HUB_STATUS_OFS && d[16]) pwr = pwr | sel;
    q.push_back(a != `RHS_ROOT_HUB_STATUS_OFS ? 32'h0 :
      {14'h0, chg, 1'b0, wake, 13'h0, oc, 1'b0});
    qp.push_back(pwr);
    qr.push_back(wake && HOST_SUSPENDED_STATE && (|PORT_CONNECT_CHANGE));
    @(posedge CLK); REG_RD <= 0;
  endtask
  initial begin
    forever #5 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    rd_d <= REG_RD;
    if (rd_d) begin
      chk_rd(q.pop_front(), REG_RDATA);
      chk_pwr(qp.pop_front(), PORT_POWER_ON);
      chk_res(qr.pop_front(), RESUME_DETECTED);
    end
    if (cyc == 1000) begin
      n_fail++;
      report_and_stop();
    end
  end
  // ============================================================
  // main sequence
  initial begin
    repeat (4) @(posedge CLK);
    RST_N <= 1;
    xfer(`RHS_ROOT_HUB_STATUS_OFS, 32'h0, 0);
    xfer(12'h054, 32'h0000_8000, 1);
    xfer(`RHS_ROOT_HUB_STATUS_OFS, 32'h0, 0);
    repeat (60) begin
      x = xs();
      POWER_SWITCH_MODE <= x[20];
      PORT_POWER_MASK <= x[22:21];
      PORT_POWER_SET <= x[25:24] & x[27:26];
      PORT_POWER_CLR <= x[27:26] & x[9:8];
      HOST_SUSPENDED_STATE <= x[28];
      PORT_CONNECT_CHANGE <= x[30:29];
      xfer(`RHS_ROOT_HUB_STATUS_OFS, x & 32'h8003_8003, 1);
    end
    OVERCURRENT_IN <= 1;
    repeat (6) @(posedge CLK);
    oc = 1;
    chg = 1;
    xfer(`RHS_ROOT_HUB_STATUS_OFS, 32'h0, 1);
    xfer(`RHS_ROOT_HUB_STATUS_OFS, 32'h0002_0000, 1);
    OVERCURRENT_IN <= 0;
    // the write-one clear lands on the edge at which the flag falls
    repeat (2) @(posedge CLK);
    oc = 0;
    ev = 1;
    xfer(`RHS_ROOT_HUB_STATUS_OFS, 32'h0002_0000, 1);
    ev = 0;
    xfer(`RHS_ROOT_HUB_STATUS_OFS, 32'h0, 0);
    repeat (3) @(posedge CLK);
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
